// File: design/ccma_host.sv
// Configuration message host: builds requests, parses replies
`timescale 1ns/1ps
module ccma_host #(
    parameter int MAXB = 4
) (
    // Clock, reset and enable
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    // Command
    input  wire logic                          cmd_valid,
    output logic                               cmd_ready,
    input  wire ccma_pkg::ccma_op_e            cmd_op,
    input  wire logic [ccma_pkg::NODE_W-1:0]   cmd_node,
    input  wire logic [ccma_pkg::PERIPH_W-1:0] cmd_periph,
    input  wire logic [ccma_pkg::RET_W-1:0]    cmd_ret,
    input  wire logic [ccma_pkg::CFG_REG_W-1:0] cmd_reg,
    input  wire logic [ccma_pkg::BYTE_W-1:0]   cmd_size,
    input  wire logic [MAXB*ccma_pkg::BYTE_W-1:0] cmd_wdata,
    // Result
    output logic                               rsp_valid,
    output ccma_pkg::ccma_res_e                rsp_status,
    output logic [MAXB*ccma_pkg::BYTE_W-1:0]   rsp_rdata,
    output logic [ccma_pkg::DEST_W-1:0]        dest_addr,
    // Link out
    output logic                               tx_valid,
    output logic                               tx_ctrl,
    output logic [ccma_pkg::BYTE_W-1:0]        tx_data,
    input  wire logic                          tx_ready,
    // Link in
    input  wire logic                          rx_valid,
    input  wire logic                          rx_ctrl,
    input  wire logic [ccma_pkg::BYTE_W-1:0]   rx_data,
    output logic                               rx_ready
);
    import ccma_pkg::*;

    localparam int DW = MAXB * BYTE_W;
    localparam int PW = RET_W + CFG_REG_W + DW;

    typedef enum logic [2:0] {
        ST_IDLE, ST_HDR, ST_BODY, ST_END, ST_R_STAT, ST_R_DATA, ST_R_END
    } ccma_st_e;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    ccma_st_e          st;
    ccma_op_e          op;
    logic [PW-1:0]     payload;
    logic [7:0]        cnt;
    logic [7:0]        blen;
    logic [7:0]        nbytes;
    logic              noreply;
    logic              fail;
    logic [RET_W-1:0]  ret_q;

    ccma_tok_if txq ();
    ccma_tok_if rxq ();

    // -------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------
    wire logic                 accept;
    wire logic                 cmd_per;
    wire logic                 cmd_wr;
    wire logic                 cmd_bad;
    wire logic [7:0]           cmd_nb;
    wire logic [15:0]          shamt;
    wire logic [DW-1:0]        data_al;
    wire logic [CFG_REG_W-1:0] reg_fld;
    wire logic [DEST_W-1:0]    dest_next;
    wire logic [DEST_W-1:0]    dest_cfg;

    assign accept  = cmd_valid && cmd_ready && clk_en;
    assign cmd_per = op_is_per(cmd_op);
    assign cmd_wr  = op_is_wr(cmd_op);
    assign cmd_nb  = cmd_per ? cmd_size : 8'(WORD_BYTES);
    assign cmd_bad = cmd_per && (cmd_size > 8'(MAXB));
    // Left-align the data so its top byte leaves first
    assign shamt   = 16'(DW) - 16'({8'h00, cmd_nb} * 16'(BYTE_W));
    assign data_al = cmd_wdata << shamt; // [R3]
    // Peripheral: 8-bit register then size; config: 16-bit register
    assign reg_fld = cmd_per ? {cmd_reg[7:0], cmd_size} : cmd_reg; // [R11] [R12]
    assign dest_cfg = op_is_tile(cmd_op) ? {cmd_node, DEST_TILE_LOW}
                                         : {cmd_node, DEST_NODE_LOW}; // [R4] [R5]
    assign dest_next = cmd_per ? {cmd_node, cmd_periph, DEST_PER_LOW}
                               : dest_cfg; // [R6]

    // -------------------------------------------------------------
    // Token selection
    // -------------------------------------------------------------
    wire logic       push;
    wire logic       pop;
    wire logic [7:0] want;
    wire logic       is_ack;
    wire logic       is_nak;
    wire logic       is_end;

    assign push       = txq.valid && txq.ready;
    assign pop        = rxq.valid && rxq.ready;
    assign txq.valid  = st == ST_HDR || st == ST_BODY || st == ST_END;
    assign txq.ctrl   = st != ST_BODY;
    assign txq.data   = st == ST_HDR ? hdr_code(op) :
                        st == ST_END ? CT_END : payload[PW-1 -: BYTE_W]; // [R7] [R8]
    assign rxq.ready  = st == ST_R_STAT || st == ST_R_DATA
                        || st == ST_R_END;
    assign want       = op_is_wr(op) ? 8'h00 : nbytes;
    assign is_ack     = rxq.ctrl && rxq.data == CT_ACK;
    assign is_nak     = rxq.ctrl && rxq.data == CT_NAK;
    assign is_end     = rxq.ctrl && rxq.data == CT_END;

    // -------------------------------------------------------------
    // Completion
    // -------------------------------------------------------------
    wire logic      fin;
    wire ccma_res_e fin_res;
    wire ccma_res_e end_res;

    assign fin = clk_en && ((accept && cmd_bad)
               || (push && st == ST_END && noreply)
               || (pop && st == ST_R_STAT && !is_ack && !is_nak)
               || (pop && st == ST_R_DATA && rxq.ctrl)
               || (pop && st == ST_R_END));
    assign end_res = !is_end ? RES_PROTO : fail ? RES_FAIL : RES_OK;
    assign fin_res = st == ST_IDLE  ? RES_REFUSED :
                     st == ST_END   ? RES_OK :
                     st == ST_R_END ? end_res : RES_PROTO;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsp_valid  <= 1'b0;
            rsp_status <= RES_OK;
            cmd_ready  <= 1'b1;
        end else if (clk_en) begin
            rsp_valid <= fin;
            if (fin) begin
                rsp_status <= fin_res;
            end
            cmd_ready <= fin ? 1'b1 : accept ? 1'b0 : cmd_ready;
        end
    end

    // -------------------------------------------------------------
    // Request and reply sequencer
    // -------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st        <= ST_IDLE;
            op        <= OP_TILE_WR;
            payload   <= '0;
            cnt       <= 8'h00;
            blen      <= 8'h00;
            nbytes    <= 8'h00;
            noreply   <= 1'b0;
            fail      <= 1'b0;
            ret_q     <= '0;
            dest_addr <= '0;
            rsp_rdata <= '0;
        end else if (clk_en) begin
            case (st)
                ST_IDLE: begin
                    if (accept) begin
                        op        <= cmd_op;
                        ret_q     <= cmd_ret;
                        dest_addr <= dest_next;
                        payload   <= {cmd_ret, reg_fld, data_al}; // [R1]
                        nbytes    <= cmd_nb;
                        blen      <= 8'(HEAD_BYTES)
                                     + (cmd_wr ? cmd_nb : 8'h00); // [R7] [R8]
                        noreply   <= cmd_wr
                                     && cmd_ret[7:0] == NOREPLY_LOW; // [R2]
                        fail      <= 1'b0;
                        cnt       <= 8'h00;
                        rsp_rdata <= '0;
                        st        <= cmd_bad ? ST_IDLE : ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (push) begin
                        st <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (push) begin
                        payload <= payload << BYTE_W; // [R3]
                        cnt     <= cnt + 8'h01;
                        if (cnt == blen - 8'h01) begin
                            st <= ST_END;
                        end
                    end
                end
                ST_END: begin
                    if (push) begin
                        cnt <= 8'h00;
                        st  <= noreply ? ST_IDLE : ST_R_STAT; // [R2]
                    end
                end
                ST_R_STAT: begin
                    if (pop) begin
                        if (is_ack) begin
                            st <= want == 8'h00 ? ST_R_END : ST_R_DATA;
                        end else if (is_nak) begin
                            fail <= 1'b1;
                            st   <= ST_R_END;
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                end
                ST_R_DATA: begin
                    if (pop) begin
                        if (rxq.ctrl) begin
                            st <= ST_IDLE;
                        end else begin
                            // First byte ends up most significant
                            rsp_rdata <= {rsp_rdata[DW-BYTE_W-1:0],
                                          rxq.data}; // [R3]
                            cnt       <= cnt + 8'h01;
                            if (cnt == want - 8'h01) begin
                                st <= ST_R_END;
                            end
                        end
                    end
                end
                ST_R_END: begin
                    if (pop) begin
                        st <= ST_IDLE;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // Link stages
    // -------------------------------------------------------------
    ccma_tx u_tx (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .tok      (txq),
        .tx_valid (tx_valid),
        .tx_ctrl  (tx_ctrl),
        .tx_data  (tx_data),
        .tx_ready (tx_ready)
    );

    ccma_rx u_rx (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .rx_valid (rx_valid),
        .rx_ctrl  (rx_ctrl),
        .rx_data  (rx_data),
        .rx_ready (rx_ready),
        .tok      (rxq)
    );

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_accept;
        accept && !cmd_bad;
    endsequence
    sequence s_hdr_push;
        clk_en && push && st == ST_HDR;
    endsequence
    sequence s_end_push;
        clk_en && push && st == ST_END;
    endsequence

    a_tile_dest: assert property (s_accept and op_is_tile(cmd_op) |=> // [R4]
        dest_addr == {$past(cmd_node), DEST_TILE_LOW})
        else $error("tile destination wrong");
    a_node_dest: assert property (s_accept and !op_is_tile(cmd_op) // [R5]
        and !op_is_per(cmd_op) |=> dest_addr[15:0] == DEST_NODE_LOW)
        else $error("node destination wrong");
    a_per_dest: assert property (s_accept and op_is_per(cmd_op) |=> // [R6]
        dest_addr == {$past(cmd_node), $past(cmd_periph), DEST_PER_LOW})
        else $error("peripheral destination wrong");
    a_ret_msb_first: assert property (push && st == ST_BODY // [R1] [R3]
        && cnt < RET_BYTES |->
        txq.data == ret_q[RET_W-1-int'(cnt)*BYTE_W -: BYTE_W])
        else $error("return address byte out of order");
    a_noreply_skip: assert property (s_end_push and noreply |=> // [R2]
        rsp_valid && rsp_status == RES_OK && st == ST_IDLE)
        else $error("suppressed reply still awaited");
    a_reply_wait: assert property (s_end_push and !noreply |=> // [R1]
        st == ST_R_STAT && !rsp_valid)
        else $error("reply not awaited");
    a_cfg_wr_form: assert property (s_hdr_push and op_is_wr(op) // [R7]
        and !op_is_per(op) |-> txq.ctrl && txq.data == CT_CFG_WR
        && blen == 8'(HEAD_BYTES + WORD_BYTES))
        else $error("config write malformed");
    a_cfg_rd_form: assert property (s_hdr_push and !op_is_wr(op) // [R8]
        and !op_is_per(op) |-> txq.data == CT_CFG_RD
        && blen == 8'(HEAD_BYTES))
        else $error("config read malformed");
    a_per_wr_form: assert property (s_hdr_push and op_is_wr(op) // [R11]
        and op_is_per(op) |-> txq.data == CT_PER_WR
        && blen == 8'(HEAD_BYTES) + nbytes)
        else $error("peripheral write malformed");
    a_per_rd_form: assert property (s_hdr_push and !op_is_wr(op) // [R12]
        and op_is_per(op) |-> txq.data == CT_PER_RD
        && blen == 8'(HEAD_BYTES))
        else $error("peripheral read malformed");
endmodule

// File: design/ccma_pkg.sv
// Constants, types and decoders of the configuration message host
package ccma_pkg;
// -----------------------------------------------------------------
// Functional notes
// R1: Every request carries 24-bit reply channel address
// R2: Reply address low byte all ones: no reply (host and device model apply this to writes only)
// R3: Multi-byte fields go most significant byte first
// R4: Tile bank destination ends in C20C
// R5: Node bank destination ends in C30C
// R6: Peripheral destination: node, peripheral id, 02
// R7: Config write: 192, address, reg16, data32, 1
// R8: Config read: 193, address, reg16, 1
// R9: Device answers writes with 3,1 or 4,1
// R10: Config read answer: 3, word, 1 or 4,1
// R11: Peripheral write: 36, address, reg, size, data, 1
// R12: Peripheral read: 37, address, reg, size, 1
// R13: Peripheral read answer: 3, bytes, 1 or 4,1
// R14: Bad or protected register answered with failure
// R15: Device acts only after complete closed request
// -----------------------------------------------------------------

// -----------------------------------------------------------------
// Field widths
// -----------------------------------------------------------------
localparam int BYTE_W     = 8;
localparam int RET_W      = 24;
localparam int RET_BYTES  = 3;
localparam int CFG_REG_W  = 16;
localparam int NODE_W     = 16;
localparam int PERIPH_W   = 8;
localparam int DEST_W     = 32;
localparam int WORD_BYTES = 4;
// Return address plus two-byte register field: reg16, or peripheral register and size
localparam int HEAD_BYTES = 5;

// -----------------------------------------------------------------
// Control tokens and destination patterns
// -----------------------------------------------------------------
localparam logic [7:0]  CT_CFG_WR     = 8'hC0;
localparam logic [7:0]  CT_CFG_RD     = 8'hC1;
localparam logic [7:0]  CT_PER_WR     = 8'h24;
localparam logic [7:0]  CT_PER_RD     = 8'h25;
localparam logic [7:0]  CT_END        = 8'h01;
localparam logic [7:0]  CT_ACK        = 8'h03;
localparam logic [7:0]  CT_NAK        = 8'h04;
localparam logic [7:0]  NOREPLY_LOW   = 8'hFF;
localparam logic [15:0] DEST_TILE_LOW = 16'hC20C;
localparam logic [15:0] DEST_NODE_LOW = 16'hC30C;
localparam logic [7:0]  DEST_PER_LOW  = 8'h02;

// -----------------------------------------------------------------
// Types
// -----------------------------------------------------------------
typedef enum logic [2:0] {
    OP_TILE_WR, OP_TILE_RD, OP_NODE_WR, OP_NODE_RD, OP_PER_WR, OP_PER_RD
} ccma_op_e;

typedef enum logic [1:0] {
    RES_OK, RES_FAIL, RES_PROTO, RES_REFUSED
} ccma_res_e;

// -----------------------------------------------------------------
// Operation decoders
// -----------------------------------------------------------------
function automatic logic op_is_wr(input ccma_op_e op);
    return op == OP_TILE_WR || op == OP_NODE_WR || op == OP_PER_WR;
endfunction

function automatic logic op_is_per(input ccma_op_e op);
    return op == OP_PER_WR || op == OP_PER_RD;
endfunction

function automatic logic op_is_tile(input ccma_op_e op);
    return op == OP_TILE_WR || op == OP_TILE_RD;
endfunction

function automatic logic [7:0] hdr_code(input ccma_op_e op);
    if (op_is_per(op)) begin
        return op_is_wr(op) ? CT_PER_WR : CT_PER_RD;
    end
    return op_is_wr(op) ? CT_CFG_WR : CT_CFG_RD;
endfunction

endpackage

// File: design/ccma_rx.sv
// Incoming token register stage from the link pins
`timescale 1ns/1ps
module ccma_rx (
    // Clock, reset and enable
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Link in
    input  wire logic                      rx_valid,
    input  wire logic                      rx_ctrl,
    input  wire logic [ccma_pkg::BYTE_W-1:0] rx_data,
    output logic                           rx_ready,
    // Tokens to the parser
    ccma_tok_if.src                        tok
);
    import ccma_pkg::*;

    logic              full;
    logic              ctrl_q;
    logic [BYTE_W-1:0] data_q;
    wire logic         take;
    wire logic         drain;
    wire logic         next_full;

    assign tok.valid = full;
    assign tok.ctrl  = ctrl_q;
    assign tok.data  = data_q;
    assign take      = rx_valid && rx_ready;
    assign drain     = full && tok.ready;
    assign next_full = (full && !drain) || take;

    // Ready only while empty, so a take never overwrites
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            full     <= 1'b0;
            rx_ready <= 1'b0;
            ctrl_q   <= 1'b0;
            data_q   <= 8'h00;
        end else if (clk_en) begin
            full     <= next_full;
            rx_ready <= !next_full;
            if (take) begin
                ctrl_q <= rx_ctrl;
                data_q <= rx_data;
            end
        end
    end
endmodule

// File: design/ccma_tok_if.sv
// Token handshake carrier between the host's own modules
`timescale 1ns/1ps
interface ccma_tok_if;
    logic       valid;
    logic       ready;
    logic       ctrl;
    logic [7:0] data;
    modport src (output valid, output ctrl, output data, input ready);
    modport snk (input valid, input ctrl, input data, output ready);
endinterface

// File: design/ccma_tx.sv
// Outgoing token register stage driving the link pins
`timescale 1ns/1ps
module ccma_tx (
    // Clock, reset and enable
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Tokens from the sequencer
    ccma_tok_if.snk                        tok,
    // Link out
    output logic                           tx_valid,
    output logic                           tx_ctrl,
    output logic [ccma_pkg::BYTE_W-1:0]    tx_data,
    input  wire logic                      tx_ready
);
    import ccma_pkg::*;

    wire logic load;

    assign tok.ready = !tx_valid || tx_ready;
    assign load      = tok.valid && tok.ready;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_ctrl  <= 1'b0;
            tx_data  <= 8'h00;
        end else if (clk_en) begin
            if (load) begin
                tx_valid <= 1'b1;
                tx_ctrl  <= tok.ctrl;
                tx_data  <= tok.data;
            end else if (tx_ready) begin
                tx_valid <= 1'b0;
            end
        end
    end
endmodule

// File: testbench/ccma_dev_model.sv
// Behavioural configuration device on the far side of the host
`timescale 1ns/1ps
module ccma_dev_model #(
    parameter logic [15:0] NODE_ID = 16'h4E21
) (
    // Clock and control
    input  wire logic        core_clk,
    input  wire logic        clk_en,
    input  wire logic        slow,
    input  wire logic        junk,
    // Host request side
    input  wire logic [31:0] dest_addr,
    input  wire logic        tx_valid,
    input  wire logic        tx_ctrl,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    // Reply side
    output logic             rx_valid,
    output logic             rx_ctrl,
    output logic [7:0]       rx_data,
    input  wire logic        rx_ready,
    // Observation
    output int               n_bad,
    output int               n_rep,
    output int               n_tok,
    output logic [23:0]      last_ret
);
    import ccma_pkg::*;
    logic [8:0]  req[$];
    logic [8:0]  rep[$];
    logic [31:0] cfg[2][16];
    logic [7:0]  per[64];
    logic        ph = 1'b0;

    initial begin
        {tx_ready, rx_valid, rx_ctrl, rx_data} = 11'h000;
        {n_bad, n_rep, n_tok} = 96'h0;
        foreach (cfg[i, j]) cfg[i][j] = 32'h0;
        foreach (per[i]) per[i] = 8'h00;
    end

    // Decode a closed request, apply it, queue the reply
    task automatic serve();
        logic [7:0] b[$];
        logic [7:0] h;
        logic       wr, pr, ok, bad;
        int         r, n, k, t;
        h = req[0][7:0];
        bad = !req[0][8];
        for (k = 1; k < req.size() - 1; k++) begin
            bad |= req[k][8];
            b.push_back(req[k][7:0]);
        end
        pr = h == CT_PER_WR || h == CT_PER_RD;
        wr = h == CT_CFG_WR || h == CT_PER_WR;
        bad |= !(pr || h == CT_CFG_WR || h == CT_CFG_RD);
        last_ret = {b[0], b[1], b[2]};
        r = pr ? int'(b[3]) : int'({b[3], b[4]});
        n = pr ? int'(b[4]) : 4;
        bad |= b.size() != 5 + (wr ? n : 0);
        bad |= dest_addr[31:16] != NODE_ID;
        if (pr)
            bad |= dest_addr[7:0] != DEST_PER_LOW;
        else
            bad |= dest_addr[15:0] != DEST_TILE_LOW
                && dest_addr[15:0] != DEST_NODE_LOW;
        t = dest_addr[15:0] == DEST_NODE_LOW;
        // Register 15 is write protected, 16 and up absent
        ok = !bad && (pr ? r + n <= 64 : r < 15 || (r == 15 && !wr));
        for (k = 0; ok && wr && k < n; k++) begin
            if (pr) per[r + k] = b[5 + k];
            else cfg[t][r][31 - 8 * k -: 8] = b[5 + k];
        end
        // Junk mode answers with a lone closing token
        if (junk) begin
            rep.push_back({1'b1, CT_END});
        end else if (!(wr && last_ret[7:0] == NOREPLY_LOW)) begin
            n_rep++;
            rep.push_back({1'b1, ok ? CT_ACK : CT_NAK});
            for (k = 0; ok && !wr && k < n; k++)
                rep.push_back({1'b0, pr ? per[r + k]
                                        : cfg[t][r][31 - 8 * k -: 8]});
            rep.push_back({1'b1, CT_END});
        end
        n_bad += bad;
        req.delete();
    endtask

    always @(posedge core_clk) begin
        ph <= ~ph;
        tx_ready <= !slow || ph;
        if (tx_valid && tx_ready && clk_en) begin
            n_tok++;
            req.push_back({tx_ctrl, tx_data});
            if (tx_ctrl && tx_data == CT_END) serve();
        end
        if (rx_valid) begin
            if (rx_ready && clk_en) begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                rep.delete(0);
            end
        end else if (rep.size() > 0 && (!slow || ph)) begin
            rx_valid <= 1'b1;
            {rx_ctrl, rx_data} <= rep[0];
        end
    end
endmodule

// File: testbench/tb_ccma_host.sv
// Self-checking bench of the configuration message host
`timescale 1ns/1ps
module tb_ccma_host;
    import ccma_pkg::*;
    localparam logic [15:0] NODE = 16'h4E21;
    localparam logic [7:0]  PID  = 8'h5A;
    logic core_clk = 1'b0;
    logic clk_en = 1'b1;
    logic rst_n, gate, slow, junk, cmd_valid, cmd_ready, rsp_valid;
    logic tx_valid, tx_ctrl, tx_ready, rx_valid, rx_ctrl, rx_ready;
    logic [7:0]  cmd_size, tx_data, rx_data;
    logic [15:0] cmd_reg;
    logic [23:0] cmd_ret, last_ret;
    logic [31:0] cmd_wdata, rsp_rdata, dest_addr, rd;
    logic [1:0]  cyc = 2'b00;
    ccma_op_e    cmd_op;
    ccma_res_e   rsp_status, st;
    int          n_bad, n_rep, n_tok, fail_count, compares, k;

    ccma_host #(.MAXB(4)) DUT (
        .core_clk, .rst_n, .clk_en, .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_node(NODE), .cmd_periph(PID), .cmd_ret, .cmd_reg,
        .cmd_size, .cmd_wdata, .rsp_valid, .rsp_status, .rsp_rdata,
        .dest_addr, .tx_valid, .tx_ctrl, .tx_data, .tx_ready,
        .rx_valid, .rx_ctrl, .rx_data, .rx_ready);
    ccma_dev_model #(.NODE_ID(NODE)) dev (
        .core_clk, .clk_en, .slow, .junk, .dest_addr, .tx_valid, .tx_ctrl,
        .tx_data, .tx_ready, .rx_valid, .rx_ctrl, .rx_data, .rx_ready,
        .n_bad, .n_rep, .n_tok, .last_ret);

    initial forever #5 core_clk = ~core_clk;
    // Gated phases freeze one cycle in four
    always @(posedge core_clk) begin
        cyc <= cyc + 2'd1;
        clk_en <= !gate || cyc != 2'b00;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // One command from accept to result, bounded
    task automatic run(input ccma_op_e op, input logic [15:0] rg,
                       input logic [7:0] sz, input logic [23:0] rt,
                       input logic [31:0] wd);
        int i;
        cmd_op <= op;
        cmd_reg <= rg;
        cmd_size <= sz;
        cmd_ret <= rt;
        cmd_wdata <= wd;
        cmd_valid <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (!(cmd_ready && clk_en) && i < 100);
        cmd_valid <= 1'b0;
        do begin
            @(posedge core_clk);
            i++;
        end while (!rsp_valid && i < 900);
        if (i >= 900) begin
            fail_count++;
            finish_test();
        end
        st = rsp_status;
        rd = rsp_rdata;
    endtask

    task automatic t_cfg();
        run(OP_TILE_WR, 16'h0002, 8'h00, 24'h0102AB, 32'h1234ABCD);
        check(st, RES_OK);
        check(last_ret, 24'h0102AB);
        check(dest_addr, {NODE, DEST_TILE_LOW});
        run(OP_NODE_WR, 16'h0002, 8'h00, 24'h0102AB, 32'h89EF0123);
        check(dest_addr, {NODE, DEST_NODE_LOW});
        run(OP_TILE_RD, 16'h0002, 8'h00, 24'h0102AB, 32'h0);
        check(rd, 32'h1234ABCD);
        run(OP_NODE_RD, 16'h0002, 8'h00, 24'h0102AB, 32'h0);
        check(rd, 32'h89EF0123);
    endtask

    task automatic t_norep();
        k = n_rep;
        run(OP_NODE_WR, 16'h0007, 8'h00, 24'h0102FF, 32'hCAFE0007);
        check(st, RES_OK);
        check(n_rep, k);
        run(OP_NODE_RD, 16'h0007, 8'h00, 24'h0102FF, 32'h0);
        check(rd, 32'hCAFE0007);
        check(n_rep, k + 1);
    endtask

    task automatic t_fail();
        run(OP_TILE_RD, 16'h0100, 8'h00, 24'h0102AB, 32'h0);
        check(st, RES_FAIL);
        run(OP_TILE_WR, 16'h000F, 8'h00, 24'h0102AB, 32'h55AA55AA);
        check(st, RES_FAIL);
        run(OP_TILE_RD, 16'h000F, 8'h00, 24'h0102AB, 32'h0);
        check(rd, 32'h0);
        run(OP_PER_RD, 16'h003E, 8'h04, 24'h0102AB, 32'h0);
        check(st, RES_FAIL);
        junk <= 1'b1;
        run(OP_NODE_RD, 16'h0002, 8'h00, 24'h0102AB, 32'h0);
        check(st, RES_PROTO);
        junk <= 1'b0;
    endtask

    task automatic t_per();
        slow <= 1'b1;
        gate <= 1'b1;
        run(OP_PER_WR, 16'h0008, 8'h03, 24'h0102AB, 32'h00A1B2C3);
        check(st, RES_OK);
        check(dest_addr, {NODE, PID, DEST_PER_LOW});
        run(OP_PER_RD, 16'h0009, 8'h02, 24'h0102AB, 32'h0);
        check(rd, 32'h0000B2C3);
        run(OP_PER_RD, 16'h0008, 8'h00, 24'h0102AB, 32'h0);
        check(st, RES_OK);
        k = n_tok;
        run(OP_PER_WR, 16'h0008, 8'h05, 24'h0102AB, 32'h0);
        check(st, RES_REFUSED);
        check(n_tok, k);
        slow <= 1'b0;
        gate <= 1'b0;
    endtask

    initial begin
        {rst_n, gate, slow, junk, cmd_valid} = 5'b00000;
        cmd_op = OP_TILE_WR;
        {cmd_reg, cmd_size, cmd_ret, cmd_wdata} = 80'h0;
        {fail_count, compares} = 64'h0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_cfg();
        t_norep();
        t_fail();
        t_per();
        check(n_bad, 0);
        finish_test();
    end
endmodule
